/* tbd_timer.sv */
// tbd_timer: periodic tick timer and buzzer divider output behind an axi4-lite slave
//
// What this block does
// - one 8-bit control register, all zero at reset
// - enabled timer raises periodic interrupt; disabled, none
// - rate code picks high or low clock tap
// - low-speed modes: only codes 000, 001 work
// - rate and enable may be written together
// - interrupt on each falling edge of tap
// - enabling never clears the shared divider
// - buzzer gets half-duty square wave from tap
// - output enable bit gates the buzzer wave
// - buzzer rate code picks high or low tap
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tbd_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [tbd_pkg::TBD_HF_W-1:0] hf_div,
    input wire logic [tbd_pkg::TBD_LF_W-1:0] lf_div,
    input wire logic low_speed_mode,
    input wire logic awvalid,
    output logic awready,
    input wire logic [tbd_pkg::TBD_ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [tbd_pkg::TBD_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [tbd_pkg::TBD_ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [tbd_pkg::TBD_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic tbt_irq,
    output logic buzzer_out_n
);
    import tbd_pkg::*;

    typedef struct packed {
        logic aw_full;
        logic [TBD_IDX_W-1:0] aw_idx;
        logic w_full;
        logic [7:0] w_byte;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rbyte;
        logic [1:0] rresp;
        logic [7:0] ctl;
        logic buz_n;
    } tbd_regs_s;

    tbd_regs_s s;
    tbd_regs_s next_s;

    logic tbt_enable;
    logic dvo_enable;
    logic slow_clk_select;
    logic [2:0] tbt_rate_sel;
    logic [1:0] dvo_rate_sel;
    logic tbt_use_lf;
    logic dvo_use_lf;
    logic tbt_tap;
    logic dvo_tap;
    logic tbt_valid;
    logic tbt_run;
    logic tbt_level;
    logic tbt_fall;
    logic dvo_level;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_go;
    logic [TBD_IDX_W-1:0] ar_idx;
    logic [7:0] status;

    // ---------------------------------------------------------------
    // control fields
    // ---------------------------------------------------------------
    assign tbt_enable = s.ctl[TBD_TBT_EN_BIT];
    assign dvo_enable = s.ctl[TBD_DVO_EN_BIT];
    assign slow_clk_select = s.ctl[TBD_SLOW_BIT];
    assign tbt_rate_sel = s.ctl[TBD_TBT_SEL_HI:TBD_TBT_SEL_LO];
    assign dvo_rate_sel = s.ctl[TBD_DVO_SEL_HI:TBD_DVO_SEL_LO];

    // ---------------------------------------------------------------
    // tap selection from the free-running shared divider
    // ---------------------------------------------------------------
    // the divider is an input and never cleared here, so the first tick may come early
    assign tbt_use_lf = slow_clk_select | low_speed_mode;
    assign dvo_use_lf = slow_clk_select | low_speed_mode;
    assign tbt_tap = tbt_use_lf ? lf_div[TBD_TBT_LF_TAP[tbt_rate_sel]] : hf_div[TBD_TBT_HF_TAP[tbt_rate_sel]];
    assign dvo_tap = dvo_use_lf ? lf_div[TBD_DVO_LF_TAP[dvo_rate_sel]] : hf_div[TBD_DVO_HF_TAP[dvo_rate_sel]];
    // codes without a defined low-speed rate stay silent
    assign tbt_valid = !low_speed_mode || (tbt_rate_sel < TBD_LS_TBT_CODES);
    assign tbt_run = tbt_enable & tbt_valid;

    // tick edge detector
    tbd_edge_tap u_tbt_edge (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .en(tbt_run),
        .tap_in(tbt_tap),
        .level(tbt_level),
        .fall(tbt_fall)
    );

    // buzzer tap sampler
    tbd_edge_tap u_dvo_edge (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .en(dvo_enable),
        .tap_in(dvo_tap),
        .level(dvo_level),
        .fall()
    );

    assign status = {5'h00, low_speed_mode, s.buz_n, tbt_level};

    // ---------------------------------------------------------------
    // axi4-lite handshakes
    // ---------------------------------------------------------------
    // readies drop with ce so no beat is taken while state is frozen
    assign awready = ce & ~s.aw_full;
    assign wready = ce & ~s.w_full;
    assign arready = ce & ~s.rvalid;
    assign aw_fire = awvalid & awready;
    assign w_fire = wvalid & wready;
    assign ar_fire = arvalid & arready;
    assign wr_go = s.aw_full & s.w_full & ~s.bvalid;
    assign ar_idx = araddr[TBD_ADDR_W-1:2];

    // next-state logic: bus slave, control register and buzzer pin
    always_comb begin
        next_s = s;
        if (aw_fire) begin
            next_s.aw_full = 1'b1;
            next_s.aw_idx = awaddr[TBD_ADDR_W-1:2];
        end
        if (w_fire) begin
            next_s.w_full = 1'b1;
            next_s.w_byte = wdata[7:0];
            next_s.w_lane = wstrb[0];
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_go) begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = TBD_RESP_OKAY;
            if (s.aw_idx == TBD_CTRL_INDEX) begin
                if (s.w_lane) begin
                    next_s.ctl = s.w_byte;
                end
            end else if (s.aw_idx != TBD_STAT_INDEX) begin
                next_s.bresp = TBD_RESP_SLVERR;
            end
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = TBD_RESP_OKAY;
            if (ar_idx == TBD_CTRL_INDEX) begin
                next_s.rbyte = s.ctl;
            end else if (ar_idx == TBD_STAT_INDEX) begin
                next_s.rbyte = status;
            end else begin
                next_s.rbyte = 8'h00;
                next_s.rresp = TBD_RESP_SLVERR;
            end
        end
        // active-low pin: drives the inverted tap, rests high when disabled
        next_s.buz_n = dvo_enable ? ~dvo_level : 1'b1;
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
            s.ctl <= TBD_CTRL_RESET;
            s.buz_n <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = {24'h000000, s.rbyte};
    assign tbt_irq = tbt_fall;
    assign buzzer_out_n = s.buz_n;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    ctrl_reset_a: assert property (@(posedge clk) !rstn |=> s.ctl == TBD_CTRL_RESET)
        else $error("control register not cleared by reset");

    ctrl_write_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && wr_go && s.aw_idx == TBD_CTRL_INDEX && s.w_lane) |=> s.ctl == $past(s.w_byte))
        else $error("control write not stored");

    irq_off_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && !tbt_enable) |=> !tbt_irq)
        else $error("tick while timer disabled");

    ls_code_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && low_speed_mode && tbt_rate_sel >= TBD_LS_TBT_CODES) |=> !tbt_irq)
        else $error("tick on undefined low-speed code");

    irq_edge_a: assert property (@(posedge clk) disable iff (!rstn)
        (tbt_irq && $past(ce) && $past(ce, 2)) |-> ($past(tbt_tap) == 1'b0 && $past(tbt_tap, 2) == 1'b1))
        else $error("tick without falling tap edge");

    irq_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
        (tbt_irq && ce) |=> !tbt_irq)
        else $error("tick longer than one cycle");

    buz_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && !dvo_enable) |=> buzzer_out_n)
        else $error("buzzer pin active while disabled");

    buz_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && dvo_enable) ##1 (ce && dvo_enable) |=> buzzer_out_n == !$past(dvo_tap, 2))
        else $error("buzzer pin not following tap");

    bresp_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (bvalid && !bready) |=> (bvalid && $stable(bresp)))
        else $error("write response dropped early");

    rd_unmapped_a: assert property (@(posedge clk) disable iff (!rstn)
        (ar_fire && ar_idx != TBD_CTRL_INDEX && ar_idx != TBD_STAT_INDEX) |=> (rvalid && rresp == TBD_RESP_SLVERR))
        else $error("unmapped read not refused");

    // ---------------------------------------------------------------
    // tick, bus and clock-enable assertions
    // ---------------------------------------------------------------
    // arming lags the enable, so the cycle after enabling carries no tick
    tick_arm_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && $past(ce) && $rose(tbt_run)) |=> !tbt_irq)
        else $error("tick right after enabling");

    // a fresh tick needs the timer running on the edge that made it
    irq_enable_a: assert property (@(posedge clk) disable iff (!rstn)
        (tbt_irq && $past(ce)) |-> $past(tbt_run))
        else $error("tick raised while timer not running");

    // a control read returns the register as it stood when taken
    rd_ctrl_a: assert property (@(posedge clk) disable iff (!rstn)
        (ar_fire && ar_idx == TBD_CTRL_INDEX) |=> (rvalid && rresp == TBD_RESP_OKAY && rdata == {24'h000000, $past(s.ctl)}))
        else $error("control read data wrong");

    // the read answer follows the address handshake by one cycle
    rd_next_a: assert property (@(posedge clk) disable iff (!rstn)
        ar_fire |=> rvalid)
        else $error("read answer missing");

    // writes elsewhere leave the control register alone
    wr_keep_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && wr_go && s.aw_idx != TBD_CTRL_INDEX) |=> s.ctl == $past(s.ctl))
        else $error("control changed by foreign write");

    // an unmapped write is answered with a slave error
    wr_refuse_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && wr_go && s.aw_idx != TBD_CTRL_INDEX && s.aw_idx != TBD_STAT_INDEX) |=> (bvalid && bresp == TBD_RESP_SLVERR))
        else $error("unmapped write not refused");

    // every executed write raises its response
    wr_resp_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && wr_go) |=> bvalid)
        else $error("write response missing");

    // clock enable low freezes the whole register state
    state_freeze_a: assert property (@(posedge clk) disable iff (!rstn)
        !ce |=> $stable(s))
        else $error("state moved while clock enable low");

    // no beat can be taken while the state is frozen
    ready_off_a: assert property (@(posedge clk) disable iff (!rstn)
        !ce |-> (!awready && !wready && !arready))
        else $error("ready raised while clock enable low");
endmodule
`default_nettype wire

/* tbd_pkg.sv */
// tbd_pkg: shared constants for the time base timer and divider output block
package tbd_pkg;
    // ---------------------------------------------------------------
    // bus and register map
    // ---------------------------------------------------------------
    localparam int TBD_ADDR_W = 16;
    localparam int TBD_DATA_W = 32;
    localparam int TBD_IDX_W = 14;
    localparam logic [TBD_IDX_W-1:0] TBD_CTRL_INDEX = 14'h0036;
    localparam logic [TBD_IDX_W-1:0] TBD_STAT_INDEX = 14'h0037;
    localparam logic [7:0] TBD_CTRL_RESET = 8'h00;
    localparam logic [1:0] TBD_RESP_OKAY = 2'h0;
    localparam logic [1:0] TBD_RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // control field positions
    // ---------------------------------------------------------------
    localparam int TBD_DVO_EN_BIT = 7;
    localparam int TBD_DVO_SEL_HI = 6;
    localparam int TBD_DVO_SEL_LO = 5;
    localparam int TBD_SLOW_BIT = 4;
    localparam int TBD_TBT_EN_BIT = 3;
    localparam int TBD_TBT_SEL_HI = 2;
    localparam int TBD_TBT_SEL_LO = 0;

    // ---------------------------------------------------------------
    // divider taps: bit k of a divider vector runs at clock/2^k
    // ---------------------------------------------------------------
    localparam int TBD_HF_W = 24;
    localparam int TBD_LF_W = 16;
    localparam logic [2:0] TBD_LS_TBT_CODES = 3'h2;
    localparam logic [4:0] TBD_TBT_HF_TAP [8] = '{5'h17, 5'h15, 5'h10, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h09};
    localparam logic [3:0] TBD_TBT_LF_TAP [8] = '{4'hf, 4'hd, 4'h8, 4'h6, 4'h5, 4'h4, 4'h3, 4'h1};
    localparam logic [4:0] TBD_DVO_HF_TAP [4] = '{5'h0d, 5'h0c, 5'h0b, 5'h0a};
    localparam logic [3:0] TBD_DVO_LF_TAP [4] = '{4'h5, 4'h4, 4'h3, 4'h2};
endpackage

/* tbd_edge_tap.sv */
// tbd_edge_tap: samples one divider tap and flags its falling edges
`timescale 1ns/1ps
`default_nettype none
module tbd_edge_tap (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic en,
    input wire logic tap_in,
    output logic level,
    output logic fall
);
    import tbd_pkg::*;

    typedef struct packed {
        logic cur;
        logic armed;
        logic fall;
    } tbd_edge_s;

    tbd_edge_s s;
    tbd_edge_s next_s;

    // ---------------------------------------------------------------
    // edge detection
    // ---------------------------------------------------------------
    // armed lags enable by one cycle so a tap swapped in the enabling write cannot fake an edge
    always_comb begin
        next_s = s;
        next_s.cur = tap_in;
        next_s.armed = en;
        next_s.fall = en & s.armed & s.cur & ~tap_in;
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign level = s.cur;
    assign fall = s.fall;
endmodule
`default_nettype wire

/* tbd_far_model.sv */
// tbd_far_model: shared divider source and observer of the tick request and buzzer pin
`timescale 1ns/1ps
`default_nettype none
module tbd_far_model (
    input wire logic clk,
    input wire logic clr,
    input wire logic tbt_irq,
    input wire logic buzzer_out_n,
    output logic [tbd_pkg::TBD_HF_W-1:0] hf_div,
    output logic [tbd_pkg::TBD_LF_W-1:0] lf_div,
    output int irq_count,
    output int low_count,
    output int buz_edges
);
    import tbd_pkg::*;
    logic pin_latch;
    logic port1_direction;
    logic pin;
    logic pin_q;
    // dividers start at zero and run free; software readies the shared pin latch first, then its direction
    initial begin
        hf_div = '0;
        lf_div = '0;
        pin_latch = 1'b1;
        port1_direction = 1'b1;
        pin_q = 1'b1;
    end
    // an undriven pin rests at its pull-up level
    assign pin = (port1_direction && pin_latch) ? buzzer_out_n : 1'b1;
    // step of two so bit k runs at the clock over 2^k; never cleared by the timer
    always @(posedge clk) begin
        hf_div <= hf_div + 24'h000002;
        lf_div <= lf_div + 16'h0002;
    end
    // interrupt side tallies request cycles, buzzer side tallies low cycles and falling edges
    always @(posedge clk) begin
        irq_count <= clr ? 0 : irq_count + int'(tbt_irq);
        low_count <= clr ? 0 : low_count + int'(!pin);
        buz_edges <= clr ? 0 : buz_edges + int'(pin_q & !pin);
        pin_q <= pin;
    end
endmodule
`default_nettype wire

/* tbd_timer_tb_top.sv */
// tbd_timer_tb_top: self-checking bench for the tick timer and buzzer output
`timescale 1ns/1ps
`default_nettype none
module tbd_timer_tb_top;
    import tbd_pkg::*;
    localparam logic [15:0] CTRL_ADDR = 16'h00d8; // index times four
    localparam logic [15:0] BAD_ADDR = 16'h0100;
    localparam logic [15:0] STAT_ADDR = 16'h00dc;
    logic clk = 1'b0, rstn = 1'b0, low_speed_mode = 1'b0, clr = 1'b1, ce = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic awready, wready, bvalid, arready, rvalid, tbt_irq, buzzer_out_n;
    logic [1:0] bresp, rresp;
    logic [TBD_HF_W-1:0] hf_div;
    logic [TBD_LF_W-1:0] lf_div;
    int irq_count, low_count, buz_edges, fail_count = 0, checks_done = 0;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [2:0] cd [10] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7, 3'h1, 3'h2};
    logic sl [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    int lft [8] = '{15, 13, 8, 6, 5, 4, 3, 1};
    int hft [8] = '{23, 21, 16, 14, 13, 12, 11, 9};
    int lfd [4] = '{5, 4, 3, 2};
    int hfd [4] = '{13, 12, 11, 10};

    always #4 clk = ~clk;

    tbd_timer i_tbd_timer (.clk(clk), .rstn(rstn), .ce(ce), .hf_div(hf_div), .lf_div(lf_div),
        .low_speed_mode(low_speed_mode), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(1'b1),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(1'b1), .rdata(rdata), .rresp(rresp), .tbt_irq(tbt_irq), .buzzer_out_n(buzzer_out_n));
    tbd_far_model i_tbd_far_model (.clk(clk), .clr(clr), .tbt_irq(tbt_irq), .buzzer_out_n(buzzer_out_n),
        .hf_div(hf_div), .lf_div(lf_div), .irq_count(irq_count), .low_count(low_count),
        .buz_edges(buz_edges));

    // -------------------------------------------------------------
    // compare, close and bus tasks
    // -------------------------------------------------------------
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // write: offer address and data together, drop each when taken
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        logic ad, wd;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        bq.push_back(r);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h000000, d};
        // each channel is released once, at the edge that takes it
        do begin
            @(posedge clk);
            if (!ad && awready === 1'b1) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (!wd && wready === 1'b1) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        if (bvalid !== 1'b1) begin
            fail_count++;
            finish_test();
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        n = 0;
        rq.push_back({r, 24'h000000, d});
        arvalid <= 1'b1;
        araddr <= a;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        if (rvalid !== 1'b1) begin
            fail_count++;
            finish_test();
        end
    endtask

    // response watcher takes the oldest note for each answer
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rq.size() > 0) chk({rresp, rdata}, rq.pop_front());
        if (bvalid === 1'b1 && bq.size() > 0) chk({32'h00000000, bresp}, {32'h00000000, bq.pop_front()});
    end

    // -------------------------------------------------------------
    // main sequence: each case runs a whole window of 8192 cycles
    // -------------------------------------------------------------
    initial begin
        int seed, exp, k;
        logic de;
        logic [1:0] ds;
        logic [7:0] prev, nw;
        seed = $urandom(32'h008b0edf);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(CTRL_ADDR, 8'h00, TBD_RESP_OKAY);
        rd(STAT_ADDR, 8'h02, TBD_RESP_OKAY);
        wr(BAD_ADDR, 8'hff, TBD_RESP_SLVERR);
        rd(BAD_ADDR, 8'h00, TBD_RESP_SLVERR);
        prev = 8'h00;
        for (int i = 0; i < 10; i++) begin
            de = 1'($urandom);
            ds = 2'($urandom);
            nw = {de, ds, sl[i], i != 5, cd[i]};
            wr(CTRL_ADDR, prev & 8'h77, TBD_RESP_OKAY);
            wr(CTRL_ADDR, {1'b0, ds, sl[i], 1'b0, prev[2:0]}, TBD_RESP_OKAY);
            low_speed_mode <= (i >= 8);
            wr(CTRL_ADDR, nw, TBD_RESP_OKAY);
            rd(CTRL_ADDR, nw, TBD_RESP_OKAY);
            repeat (40) @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (8193) @(posedge clk);
            if (i == 5 || (i >= 8 && cd[i] >= 3'h2))
                exp = 0;
            else if (sl[i] || i >= 8)
                exp = 8192 >> lft[cd[i]];
            else
                exp = 8192 >> hft[cd[i]];
            chk(34'(irq_count), 34'(exp));
            chk(34'(low_count), de ? 34'h1000 : 34'h0);
            k = (sl[i] || i >= 8) ? lfd[ds] : hfd[ds];
            chk(34'(buz_edges), de ? 34'(8192 >> k) : 34'h0);
            prev = nw;
        end
        // frozen clock enable keeps the register, then a mid-run reset clears it
        ce <= 1'b0;
        repeat (6) @(posedge clk);
        ce <= 1'b1;
        rd(CTRL_ADDR, prev, TBD_RESP_OKAY);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        rd(CTRL_ADDR, 8'h00, TBD_RESP_OKAY);
        finish_test();
    end
endmodule
`default_nettype wire
